// File: hw/swm_engine.sv
/*
  Memory-function command engine of a single-wire battery monitor:
  skip-select, page and field CRC reads, flash and RAM writes,
  page erase, profile byte and the self-clearing counter clear.
  Assumes a bit-slot layer on clk_i that strobes received bits and
  read slots, and reports bus reset and identity selection.
*/
`timescale 1ns/1ps
module swm_engine
    import swm_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    // Bit-slot layer
    input  wire logic                     bus_reset_i,
    input  wire logic                     rom_select_i,
    input  wire swm_pkg::swm_link_in_type link_i,
    output swm_pkg::swm_link_out_type     link_o,
    // Monitor registers
    input  wire logic [15:0][7:0]         reg_rd_i,
    output logic                          reg_wr_o,
    output logic      [3:0]               reg_wr_addr_o,
    output logic      [7:0]               reg_wr_data_o,
    // Counter maintenance
    input  wire logic                     dt_rollover_i,
    input  wire logic                     ct_rollover_i,
    output logic      [4:0]               counter_clear_o,
    output logic                          discharge_timer_rollover_flag_o,
    output logic                          charge_timer_rollover_flag_o,
    output logic      [7:0]               mode_o,
    // Status
    output logic                          selected_o
);
    import swm_pkg::*;

    typedef struct packed {
        swm_state_type    st;
        swm_then_type     then_step;
        logic             page_mode;
        logic             last;
        logic             wback;
        logic             sel;
        logic [7:0]       cmd;
        logic [7:0]       addr_lo;
        logic [8:0]       addr;
        logic [7:0]       crc;
        logic [7:0]       rx_sh;
        logic [2:0]       rx_cnt;
        logic [7:0]       tx_sh;
        logic [2:0]       tx_cnt;
        logic [7:0]       buf_byte;
        logic [4:0]       ecnt;
        logic [7:0]       clr_reg;
        logic [7:0]       mode_reg;
        swm_link_out_type link;
        logic             reg_wr;
        logic [3:0]       reg_wr_addr;
        logic [7:0]       reg_wr_data;
        logic [4:0]       clr_pulse;
        logic             mem_we;
        logic [7:0]       mem_addr;
        logic [7:0]       mem_wdata;
    } swm_regs_type;

    localparam swm_regs_type REGS_RESET = '{
        st: ST_IDLE, then_step: TN_DONE, clr_reg: CLR_RESET,
        mode_reg: MODE_RESET, default: '0};

    swm_regs_type r_reg;
    swm_regs_type r_next;
    logic [7:0]   mem_rdata;

    swm_byte_ram #(.ADDR_W(8), .DATA_W(8)) u_ram (
        .clk_i  (clk_i),
        .we_i   (r_reg.mem_we),
        .addr_i (r_reg.mem_addr),
        .wdata_i(r_reg.mem_wdata),
        .rdata_o(mem_rdata)
    );

    function automatic logic [7:0] reg_read(input logic [8:0] a,
                                            input swm_regs_type s);
        if (a > MAP_END) begin
            return 8'h00;
        end
        if (a == REG_CLR) begin
            return s.clr_reg;
        end
        if (a == REG_MODE) begin
            return s.mode_reg;
        end
        return reg_rd_i[a[3:0]];
    endfunction

    always_comb begin
        logic [7:0] b;
        logic       got;
        logic [8:0] a_inc;
        logic [7:0] val;
        b      = {link_i.rx_bit, r_reg.rx_sh[7:1]};
        got    = 1'b0;
        a_inc  = r_reg.addr + 9'h001;
        val    = 8'h00;
        r_next = r_reg;
        r_next.link.tx_valid = 1'b0;
        r_next.reg_wr        = 1'b0;
        r_next.mem_we        = 1'b0;
        r_next.clr_pulse     = '0;

        // Self-clearing counter clear, one cycle after the write
        if (r_reg.clr_reg[CLR_AUTO_W-1:0] != '0) begin
            r_next.clr_pulse = r_reg.clr_reg[CLR_AUTO_W-1:0];
            r_next.clr_reg[CLR_AUTO_W-1:0] = '0;
            if (r_reg.clr_reg[CLR_DTC_BIT]) begin
                r_next.mode_reg[MODE_STD_BIT] = 1'b0;
            end
            if (r_reg.clr_reg[CLR_CTC_BIT]) begin
                r_next.mode_reg[MODE_STC_BIT] = 1'b0;
            end
        end
        // Rollover toggles the flag; an event beats a same-cycle clear
        if (dt_rollover_i) begin
            r_next.mode_reg[MODE_STD_BIT] = ~r_reg.mode_reg[MODE_STD_BIT];
        end
        if (ct_rollover_i) begin
            r_next.mode_reg[MODE_STC_BIT] = ~r_reg.mode_reg[MODE_STC_BIT];
        end

        // Byte assembly, first bit lands in bit 0
        if (link_i.rx_valid && r_reg.st inside {ST_ROM, ST_CMD, ST_ALO,
                ST_AHI, ST_WDATA, ST_WCODE, ST_ECODE}) begin
            r_next.rx_sh  = b;
            r_next.rx_cnt = r_reg.rx_cnt + 3'd1;
            got           = (r_reg.rx_cnt == 3'd7);
        end

        unique case (r_reg.st)
            ST_IDLE, ST_WAITSEL: begin
                if (r_reg.st == ST_WAITSEL && rom_select_i) begin
                    r_next.st  = ST_CMD;
                    r_next.sel = 1'b1;
                end
            end
            ST_ROM: begin
                if (rom_select_i) begin
                    r_next.st  = ST_CMD;
                    r_next.sel = 1'b1;
                end else if (got) begin
                    // Other identity commands belong to the ROM layer
                    r_next.sel = (b == CMD_SKIP);
                    r_next.st  = (b == CMD_SKIP) ? ST_CMD : ST_WAITSEL;
                end
            end
            ST_CMD: begin
                if (got) begin
                    r_next.cmd       = b;
                    r_next.crc       = swm_crc8(CRC_SEED, b);
                    r_next.page_mode = (b == CMD_RD_PAGE);
                    r_next.st        = ST_IDLE; // Unknown command: silent
                    if (b inside {CMD_RD_PAGE, CMD_RD_FIELD, CMD_WRITE,
                                  CMD_ERASE}) begin
                        r_next.st = ST_ALO;
                    end else if (b == CMD_PROFILE) begin
                        r_next.st        = ST_TX;
                        r_next.tx_sh     = PROFILE_VALUE;
                        r_next.tx_cnt    = 3'd0;
                        r_next.then_step = TN_DONE;
                    end
                end
            end
            ST_ALO: begin
                if (got) begin
                    r_next.addr_lo = b;
                    r_next.crc     = swm_crc8(r_reg.crc, b);
                    r_next.st      = ST_AHI;
                end
            end
            ST_AHI: begin
                if (got) begin
                    r_next.addr   = swm_decode({b, r_reg.addr_lo});
                    r_next.crc    = swm_crc8(r_reg.crc, b);
                    r_next.tx_sh  = swm_crc8(r_reg.crc, b);
                    r_next.tx_cnt = 3'd0;
                    r_next.st     = ST_TX;
                    r_next.then_step = TN_CRC_FETCH;
                    if (r_reg.cmd == CMD_WRITE) begin
                        r_next.st = ST_WDATA;
                    end else if (r_reg.cmd == CMD_ERASE) begin
                        // Page code must be a flash page start address
                        r_next.last = ({b, r_reg.addr_lo} <= ERASE_CODE_MAX)
                            && (r_reg.addr_lo[4:0] == 5'h00);
                        r_next.buf_byte  = {5'h00, r_reg.addr_lo[7:5]};
                        r_next.then_step = TN_ECODE;
                    end
                end
            end
            ST_WDATA: begin
                if (got) begin
                    r_next.buf_byte  = b;
                    r_next.crc       = swm_crc8(r_reg.crc, b);
                    r_next.tx_sh     = swm_crc8(r_reg.crc, b);
                    r_next.tx_cnt    = 3'd0;
                    r_next.st        = ST_TX;
                    r_next.then_step = TN_WCODE;
                end
            end
            ST_WCODE: begin
                if (got) begin
                    r_next.st = (b == CODE_GO) ? ST_PRD : ST_IDLE;
                end
            end
            ST_PRD: begin
                r_next.mem_addr = r_reg.addr[7:0];
                r_next.wback    = 1'b0;
                r_next.last     = 1'b1;
                r_next.st       = ST_FWAIT;
            end
            ST_WREG: begin
                // Plain copy, no code needed above flash
                if (r_reg.addr >= REG_BASE) begin
                    if (r_reg.addr == REG_CLR) begin
                        r_next.clr_reg = r_reg.buf_byte & CLR_WR_MASK;
                    end else if (r_reg.addr == REG_MODE) begin
                        r_next.mode_reg = (r_reg.mode_reg & ~MODE_WR_MASK)
                            | (r_reg.buf_byte & MODE_WR_MASK);
                    end else if (r_reg.addr <= MAP_END) begin
                        r_next.reg_wr      = 1'b1;
                        r_next.reg_wr_addr = r_reg.addr[3:0];
                        r_next.reg_wr_data = r_reg.buf_byte;
                    end
                end else begin
                    r_next.mem_we    = 1'b1;
                    r_next.mem_addr  = r_reg.addr[7:0];
                    r_next.mem_wdata = r_reg.buf_byte;
                end
                r_next.wback = 1'b1;
                r_next.st    = ST_FETCH;
            end
            ST_FETCH: begin
                r_next.mem_addr = r_reg.addr[7:0];
                r_next.st       = ST_FWAIT;
            end
            ST_FWAIT: begin
                r_next.st = ST_FCAP;
            end
            ST_FCAP: begin
                val = (r_reg.addr >= REG_BASE) ? reg_read(r_reg.addr, r_reg)
                                               : mem_rdata;
                r_next.tx_cnt = 3'd0;
                r_next.st     = ST_TX;
                if (r_reg.cmd == CMD_WRITE && !r_reg.wback) begin
                    // Programming only clears bits of the old flash byte
                    r_next.mem_we    = 1'b1;
                    r_next.mem_addr  = r_reg.addr[7:0];
                    r_next.mem_wdata = r_reg.buf_byte & mem_rdata;
                    r_next.wback     = 1'b1;
                    r_next.st        = ST_FETCH;
                end else if (r_reg.wback) begin
                    r_next.tx_sh     = val;
                    r_next.then_step = TN_WNEXT;
                end else begin
                    r_next.tx_sh = val;
                    r_next.crc   = swm_crc8(r_reg.crc, val);
                    r_next.last  = (r_reg.addr >= MAP_END);
                    r_next.then_step = TN_FETCH;
                    if (r_reg.addr >= MAP_END || (r_reg.page_mode
                            && r_reg.addr[4:0] == PAGE_LAST_OFS)) begin
                        r_next.then_step = TN_PCRC;
                    end
                    r_next.addr = a_inc;
                end
            end
            ST_TX: begin
                if (link_i.tx_slot) begin
                    r_next.link.tx_valid = 1'b1;
                    r_next.link.tx_bit   = r_reg.tx_sh[0];
                    r_next.tx_sh  = {1'b0, r_reg.tx_sh[7:1]};
                    r_next.tx_cnt = r_reg.tx_cnt + 3'd1;
                    if (r_reg.tx_cnt == 3'd7) begin
                        r_next.tx_cnt = 3'd0;
                        r_next.rx_cnt = 3'd0;
                        unique case (r_reg.then_step)
                            TN_DONE: r_next.st = ST_IDLE;
                            TN_CRC_FETCH: begin
                                r_next.crc = CRC_SEED;
                                r_next.st  = ST_FETCH;
                            end
                            TN_FETCH: r_next.st = ST_FETCH;
                            TN_PCRC: begin
                                r_next.tx_sh     = r_reg.crc;
                                r_next.then_step = TN_AFTER_CRC;
                            end
                            TN_AFTER_CRC: begin
                                // Each page CRC starts afresh
                                r_next.crc = CRC_SEED;
                                r_next.st  = r_reg.last ? ST_IDLE
                                                        : ST_FETCH;
                            end
                            TN_WCODE: begin
                                r_next.st = (r_reg.addr <= FLASH_END)
                                    ? ST_WCODE : ST_WREG;
                            end
                            TN_WNEXT: begin
                                r_next.wback = 1'b0;
                                r_next.st    = ST_IDLE;
                                if (r_reg.addr < WRITE_MAX_START) begin
                                    r_next.addr = a_inc;
                                    r_next.crc  = a_inc[7:0];
                                    r_next.st   = ST_WDATA;
                                end
                            end
                            TN_ECODE: r_next.st = ST_ECODE;
                        endcase
                    end
                end
            end
            ST_ECODE: begin
                if (got) begin
                    r_next.ecnt = 5'h00;
                    r_next.st   = (b == CODE_GO && r_reg.last)
                        ? ST_ERASE : ST_IDLE;
                end
            end
            ST_ERASE: begin
                r_next.mem_we    = 1'b1;
                r_next.mem_addr  = {r_reg.buf_byte[2:0], r_reg.ecnt};
                r_next.mem_wdata = ERASED_BYTE;
                r_next.ecnt      = r_reg.ecnt + 5'h01;
                if (r_reg.ecnt == PAGE_LAST_OFS) begin
                    r_next.st = ST_IDLE;
                end
            end
        endcase

        // Bus reset wins over the sequence state at any point; same-cycle memory and register writes still go ahead
        if (bus_reset_i) begin
            r_next.st        = ST_ROM;
            r_next.sel       = 1'b0;
            r_next.rx_cnt    = 3'd0;
            r_next.tx_cnt    = 3'd0;
            r_next.wback     = 1'b0;
            r_next.then_step = TN_DONE;
            r_next.link.tx_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r_reg <= REGS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link_o                          = r_reg.link;
    assign reg_wr_o                        = r_reg.reg_wr;
    assign reg_wr_addr_o                   = r_reg.reg_wr_addr;
    assign reg_wr_data_o                   = r_reg.reg_wr_data;
    assign counter_clear_o                 = r_reg.clr_pulse;
    assign discharge_timer_rollover_flag_o = r_reg.mode_reg[MODE_STD_BIT];
    assign charge_timer_rollover_flag_o    = r_reg.mode_reg[MODE_STC_BIT];
    assign mode_o                          = r_reg.mode_reg;
    assign selected_o                      = r_reg.sel;
endmodule // swm_engine

// File: hw/swm_pkg.sv
/*
  Shared constants, types and helper functions of the single-wire
  memory command engine: command codes, map addresses, register bit
  positions, engine states and the link carrier structs.
  Assumes a bit-slot layer outside that frames bits on the wire.
*/
package swm_pkg;

    // Command and code bytes
    localparam logic [7:0] CMD_SKIP       = 8'hcc;
    localparam logic [7:0] CMD_RD_PAGE    = 8'hc3;
    localparam logic [7:0] CMD_RD_FIELD   = 8'hf0;
    localparam logic [7:0] CMD_WRITE      = 8'h0f;
    localparam logic [7:0] CMD_PROFILE    = 8'h99;
    localparam logic [7:0] CMD_ERASE      = 8'h40;
    localparam logic [7:0] CODE_GO        = 8'h5a;
    localparam logic [7:0] PROFILE_VALUE  = 8'h55;

    // x^8+x^5+x^4+1, bit-reversed for LSB-first shifting
    localparam logic [7:0] CRC_POLY_REFL  = 8'h8c;
    localparam logic [7:0] CRC_SEED       = 8'h00;

    // Address map
    localparam logic [15:0] ADDR_DECODE_MAX = 16'h011f;
    localparam logic [8:0]  MAP_END         = 9'h10f;
    localparam logic [8:0]  FLASH_END       = 9'h0df;
    localparam logic [8:0]  REG_BASE        = 9'h100;
    localparam logic [8:0]  REG_CLR         = 9'h104;
    localparam logic [8:0]  REG_MODE        = 9'h105;
    localparam logic [8:0]  WRITE_MAX_START = 9'h10f;
    localparam logic [4:0]  PAGE_LAST_OFS   = 5'h1f;
    localparam logic [15:0] ERASE_CODE_MAX  = 16'h00c0;
    localparam logic [7:0]  ERASED_BYTE     = 8'hff;

    // Clear register bits; the low five self-clear
    localparam int          CLR_DTC_BIT   = 3;
    localparam int          CLR_CTC_BIT   = 4;
    localparam logic [7:0]  CLR_WR_MASK   = 8'h7f;
    localparam logic [7:0]  CLR_RESET     = 8'h00;
    localparam int          CLR_AUTO_W    = 5;

    // Mode register bits
    localparam int          MODE_STD_BIT  = 4;
    localparam int          MODE_STC_BIT  = 5;
    localparam logic [7:0]  MODE_WR_MASK  = 8'h4e;
    localparam logic [7:0]  MODE_RESET    = 8'h00;

    // Default timer count period after a clear, microseconds
    localparam int          TIMER_DEFAULT_PERIOD_US = 878900;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_ROM     = 4'h1,
        ST_WAITSEL = 4'h2,
        ST_CMD     = 4'h3,
        ST_ALO     = 4'h4,
        ST_AHI     = 4'h5,
        ST_WDATA   = 4'h6,
        ST_WCODE   = 4'h7,
        ST_WREG    = 4'h8,
        ST_PRD     = 4'h9,
        ST_FETCH   = 4'ha,
        ST_FWAIT   = 4'hb,
        ST_FCAP    = 4'hc,
        ST_TX      = 4'hd,
        ST_ECODE   = 4'he,
        ST_ERASE   = 4'hf
    } swm_state_type;

    typedef enum logic [2:0] {
        TN_DONE      = 3'h0,
        TN_CRC_FETCH = 3'h1,
        TN_FETCH     = 3'h2,
        TN_PCRC      = 3'h3,
        TN_AFTER_CRC = 3'h4,
        TN_WCODE     = 3'h5,
        TN_WNEXT     = 3'h6,
        TN_ECODE     = 3'h7
    } swm_then_type;

    typedef struct packed {
        logic rx_valid;
        logic rx_bit;
        logic tx_slot;
    } swm_link_in_type;

    typedef struct packed {
        logic tx_valid;
        logic tx_bit;
    } swm_link_out_type;

    function automatic logic [7:0] swm_crc8(input logic [7:0] crc_in,
                                            input logic [7:0] data);
        logic [7:0] c;
        logic       fb;
        c = crc_in;
        for (int i = 0; i < 8; i++) begin
            fb = c[0] ^ data[i];
            c  = {1'b0, c[7:1]};
            if (fb) begin
                c = c ^ CRC_POLY_REFL;
            end
        end
        return c;
    endfunction

    // Above the decoded range the low byte repeats every 256 bytes
    function automatic logic [8:0] swm_decode(input logic [15:0] a);
        if (a <= ADDR_DECODE_MAX) begin
            return a[8:0];
        end
        return {1'b0, a[7:0]};
    endfunction

endpackage

// File: hw/swm_byte_ram.sv
/*
  Flash and RAM byte array of the command engine, one port,
  read data registered.
  Assumes the caller never reads and writes the same cycle.
*/
`timescale 1ns/1ps
module swm_byte_ram #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // Clock
    input  wire logic              clk_i,
    // Access
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic      [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem_reg [2**ADDR_W];

    // No reset: flash contents survive, RAM is undefined at power-up
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_reg[addr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[addr_i];
    end
endmodule // swm_byte_ram

// File: test/swm_engine_asserts.sv
/*
  Port-level checker of the command engine: bit answers, selection,
  counter clear pulses and rollover flags.
  Assumes it is bound to swm_engine, one clock domain.
*/
`timescale 1ns/1ps
module swm_engine_asserts (
    // Clock, reset and control
    input wire logic                      clk_i,
    input wire logic                      resetn_i,
    input wire logic                      bus_reset_i,
    input wire logic                      dt_rollover_i,
    input wire logic                      ct_rollover_i,
    input wire swm_pkg::swm_link_in_type  link_i,
    // Watched outputs
    input wire swm_pkg::swm_link_out_type link_o,
    input wire logic [4:0]                counter_clear_o,
    input wire logic                      discharge_timer_rollover_flag_o,
    input wire logic                      charge_timer_rollover_flag_o,
    input wire logic [7:0]                mode_o,
    input wire logic                      selected_o
);
    import swm_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_tx_after_slot: assert property (
        link_o.tx_valid |-> $past(link_i.tx_slot)) else $error("late bit");
    a_unsel_quiet: assert property (
        !selected_o |-> !link_o.tx_valid) else $error("unselected talk");
    a_reset_deselect: assert property (
        bus_reset_i |=> !selected_o) else $error("still selected");
    a_clear_self: assert property (
        |counter_clear_o |=> counter_clear_o == 5'h00) else $error("clear held");
    a_std_mirror: assert property (
        discharge_timer_rollover_flag_o == mode_o[MODE_STD_BIT])
        else $error("std flag");
    a_stc_mirror: assert property (
        charge_timer_rollover_flag_o == mode_o[MODE_STC_BIT])
        else $error("stc flag");
    a_dtc_flag: assert property (
        counter_clear_o[CLR_DTC_BIT] && !dt_rollover_i && !$past(dt_rollover_i)
        |-> ##[0:1] !discharge_timer_rollover_flag_o) else $error("dtc flag");
    a_ctc_flag: assert property (
        counter_clear_o[CLR_CTC_BIT] && !ct_rollover_i && !$past(ct_rollover_i)
        |-> ##[0:1] !charge_timer_rollover_flag_o) else $error("ctc flag");
    c_tx: cover property (selected_o && link_o.tx_valid);
    c_clear: cover property (|counter_clear_o);
    c_flag: cover property ($fell(discharge_timer_rollover_flag_o));
endmodule // swm_engine_asserts

// File: test/swm_host.sv
/*
  Host controller model: writes bytes and runs read slots.
  Assumes the engine answers a slot within two cycles.
*/
`timescale 1ns/1ps
module swm_host (
    input  wire logic                      clk_i,
    input  wire swm_pkg::swm_link_out_type link_i,
    output swm_pkg::swm_link_in_type       link_o
);
    import swm_pkg::*;
    initial link_o = '0;
    task automatic send_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_i) link_o = '{1'b1, v[i], 1'b0};
            @(negedge clk_i) link_o = '0;
        end
    endtask
    task automatic recv_byte(output logic [7:0] v, output logic ok);
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            // Spacing covers the fetch and flash program gaps
            repeat (6) @(negedge clk_i);
            link_o.tx_slot = 1'b1;
            @(negedge clk_i) link_o.tx_slot = 1'b0;
            // Undriven line reads high through the pull-up
            v[i] = 1'b1;
            if (link_i.tx_valid !== 1'b1) @(negedge clk_i);
            if (link_i.tx_valid === 1'b1) v[i] = link_i.tx_bit;
            else ok = 1'b0;
        end
    endtask
endmodule // swm_host

// File: test/tb_top.sv
/*
  Bench of the command engine: select, reads, writes, erase, clear.
  Assumes the host model and a 25 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
    import swm_pkg::*;
    logic             clk_i, resetn_i, bus_reset_i, rom_select_i, ok;
    logic             dt_rollover_i, ct_rollover_i, reg_wr_o, selected_o;
    logic             discharge_timer_rollover_flag_o;
    logic             charge_timer_rollover_flag_o;
    logic [15:0][7:0] reg_rd_i;
    logic [7:0]       reg_wr_data_o, mode_o, b;
    logic [4:0]       counter_clear_o;
    logic [3:0]       reg_wr_addr_o;
    swm_link_in_type  link_i;
    swm_link_out_type link_o;
    int               n_errors, comparisons, cycles;
    swm_engine i_swm_engine (.clk_i, .resetn_i, .bus_reset_i, .rom_select_i,
        .link_i, .link_o, .reg_rd_i, .reg_wr_o, .reg_wr_addr_o,
        .reg_wr_data_o, .dt_rollover_i, .ct_rollover_i, .counter_clear_o,
        .discharge_timer_rollover_flag_o, .charge_timer_rollover_flag_o,
        .mode_o, .selected_o);
    swm_host i_swm_host (.clk_i, .link_i(link_o), .link_o(link_i));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Reflected x^8+x^5+x^4+1, shifted LSB first
    function automatic logic [7:0] crc(input logic [7:0] c, d);
        for (int i = 0; i < 8; i++) begin
            c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
        end
        return c;
    endfunction
    function automatic logic [7:0] crc3(input logic [7:0] x, y, z);
        return crc(crc(crc(8'h00, x), y), z);
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tx(input logic [7:0] v);
        i_swm_host.send_byte(v);
    endtask
    task automatic rx(input logic [7:0] exp);
        i_swm_host.recv_byte(b, ok);
        cmp(b, exp);
    endtask
    task automatic quiet;
        i_swm_host.recv_byte(b, ok);
        cmp({7'h00, ok}, 8'h00);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_i) s = 1'b1;
        @(negedge clk_i) s = 1'b0;
    endtask
    task automatic start(input logic [7:0] c, lo, hi);
        pulse(bus_reset_i);
        tx(CMD_SKIP);
        tx(c);
        tx(lo);
        tx(hi);
    endtask
    task automatic t_profile;
        pulse(bus_reset_i);
        tx(CMD_PROFILE);
        quiet();
        cmp({7'h00, selected_o}, 8'h00);
        pulse(rom_select_i);
        tx(CMD_PROFILE);
        rx(PROFILE_VALUE);
        cmp({7'h00, selected_o}, 8'h01);
    endtask
    // Start one byte short of the map end: data, then the closing CRC
    task automatic t_reads;
        logic [7:0] cmd [2] = '{CMD_RD_PAGE, CMD_RD_FIELD};
        foreach (cmd[k]) begin
            start(cmd[k], 8'h0e, 8'h01);
            rx(crc3(cmd[k], 8'h0e, 8'h01));
            rx(8'h3e);
            rx(8'h3f);
            rx(crc(crc(8'h00, 8'h3e), 8'h3f));
            quiet();
        end
    endtask
    task automatic t_write;
        start(CMD_WRITE, 8'he0, 8'h00);
        tx(8'h3c);
        rx(crc(crc3(CMD_WRITE, 8'he0, 8'h00), 8'h3c));
        rx(8'h3c);
        tx(8'h11);
        rx(crc(8'he1, 8'h11));
        rx(8'h11);
    endtask
    task automatic t_flash;
        logic [7:0] d [2] = '{8'ha5, 8'h0f};
        logic [7:0] e [2] = '{8'ha5, 8'h05};
        start(CMD_ERASE, 8'h20, 8'h00);
        rx(crc3(CMD_ERASE, 8'h20, 8'h00));
        tx(CODE_GO);
        repeat (40) @(negedge clk_i);
        foreach (d[k]) begin
            start(CMD_WRITE, 8'h25, 8'h00);
            tx(d[k]);
            rx(crc(crc3(CMD_WRITE, 8'h25, 8'h00), d[k]));
            tx(CODE_GO);
            rx(e[k]);
        end
    endtask
    task automatic t_clear;
        pulse(dt_rollover_i);
        pulse(ct_rollover_i);
        cmp({6'h00, discharge_timer_rollover_flag_o,
             charge_timer_rollover_flag_o}, 8'h03);
        start(CMD_WRITE, 8'h04, 8'h01);
        tx(8'h18);
        rx(crc(crc3(CMD_WRITE, 8'h04, 8'h01), 8'h18));
        i_swm_host.recv_byte(b, ok);
        cmp({6'h00, discharge_timer_rollover_flag_o,
             charge_timer_rollover_flag_o}, 8'h00);
    endtask
    task automatic final_report;
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {resetn_i, bus_reset_i, rom_select_i} = 3'b000;
        {dt_rollover_i, ct_rollover_i} = 2'b00;
        for (int k = 0; k < 16; k++) reg_rd_i[k] = 8'h30 + 8'(k);
        repeat (16) @(negedge clk_i);
        resetn_i = 1'b1;
        t_profile();
        t_reads();
        t_write();
        t_flash();
        t_clear();
        final_report();
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            final_report();
        end
    end
endmodule // tb_top
bind swm_engine swm_engine_asserts i_swm_engine_asserts (.clk_i, .resetn_i,
    .bus_reset_i, .dt_rollover_i, .ct_rollover_i, .link_i, .link_o,
    .counter_clear_o, .discharge_timer_rollover_flag_o,
    .charge_timer_rollover_flag_o, .mode_o, .selected_o);
